// File: shared/wuc_defs.svh
// Constants of the wide up/down counter bank: counts, limits and register offsets
`ifndef WUC_DEFS_SVH
`define WUC_DEFS_SVH

`define WUC_NUM_COUNTERS  256
`define WUC_UPDOWN_LAST   8'h3f
`define WUC_UPONLY_LAST   8'hc7
`define WUC_RETAIN_BASE   100
`define WUC_MAX_POS       32'h7fffffff
`define WUC_MIN_NEG       32'h80000000
`define WUC_ONE           32'h00000001

`define WUC_OFF_DIR_LO    8'h00
`define WUC_OFF_DIR_HI    8'h04
`define WUC_OFF_SELECT    8'h08
`define WUC_OFF_VALUE     8'h0c
`define WUC_OFF_CONTACT   8'h10

`endif

// File: shared/wuc_pkg.sv
// Types shared by the wide up/down counter bank
package wuc_pkg;
  typedef enum logic {WUC_SET_CONST, WUC_SET_WORDS} wuc_setsrc_type;
  typedef logic [31:0] wuc_word_type;
endpackage

// File: design/wuc_counter_bank.sv
// Bank of 256 signed 32-bit counters with match contacts and an AHB-Lite register port
`timescale 1ns/1ps
`include "wuc_defs.svh"

// Notes on behaviour
// - 0..63 up/down, 64..199 up only, 200..255 high-speed up/down counters.
// - Setting value is any signed 32-bit two's-complement number.
// - Setting value comes from a constant or from two data words.
// - Lower word gives bits 15..0, next word bits 31..16, bit 31 sign.
// - Counting continues past the setting value, no halt or saturation.
// - Counting up, contact turns on when value reaches the setting value.
// - Counting down, contact turns off when value leaves setting for one below.
// - Clear sets current value to zero and forces the contact off.
// - Contact updates only after that counter's count step has finished, or at a power interruption for non-retentive counters.
// - Each of counters 0..63 has a direction bit: low counts up, high down; 200..255 share hsDown.
// - Counting up from the most positive value wraps to the most negative.
// - Counting down from the most negative value wraps to the most positive.
// - Non-retentive counters clear to zero on power interruption.
// - Retentive counters keep value and contact across power loss and resume.
// - Each off-to-on count input edge adds or subtracts one by direction.
module wuc_counter_bank #(
  parameter int RETAIN_BASE = `WUC_RETAIN_BASE
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Scan operation from the controller program
  input  wire logic                  scanValid,
  input  wire logic [7:0]            scanIndex,
  input  wire logic                  scanInput,
  input  wire logic                  scanClear,
  input  wire logic                  hsDown,
  input  wire wuc_pkg::wuc_setsrc_type scanSrc,
  input  wire wuc_pkg::wuc_word_type scanConst,
  input  wire logic [15:0]           scanWordLow,
  input  wire logic [15:0]           scanWordHigh,
  // Power interruption event
  input  wire logic                  powerFail,
  // Contacts
  output logic [255:0]               contact
);
  import wuc_pkg::*;

  if (RETAIN_BASE < 1 || RETAIN_BASE > 255)
  begin : g_bad_retain
    $error("RETAIN_BASE must lie in 1..255");
  end

  // Counter storage
  wuc_word_type counts [`WUC_NUM_COUNTERS];
  logic [255:0] prevInput;
  logic [63:0]  direction_select_bits;
  logic [7:0]   selIndex;

  // Scan stage: edge, direction and new value of the addressed counter
  logic         scanGo;
  logic         edgeNow;
  logic         downNow;
  wuc_word_type setNow;
  wuc_word_type curOld;
  wuc_word_type curNew;

  // Contact stage registers
  logic         p1Valid;
  logic [7:0]   p1Index;
  logic         p1Clear;
  logic         p1Edge;
  logic         p1Down;
  wuc_word_type p1Old;
  wuc_word_type p1New;
  wuc_word_type p1Set;
  logic         next_p1Valid;
  logic [7:0]   next_p1Index;
  logic         next_p1Clear;
  logic         next_p1Edge;
  logic         next_p1Down;
  wuc_word_type next_p1Old;
  wuc_word_type next_p1New;
  wuc_word_type next_p1Set;

  // A power interruption overrides any scan in the same cycle
  assign scanGo = scanValid && !powerFail;

  always_comb
  begin
    curOld  = counts[scanIndex];
    edgeNow = scanInput && !prevInput[scanIndex];
    if (scanIndex <= `WUC_UPDOWN_LAST)
      downNow = direction_select_bits[scanIndex[5:0]];
    else if (scanIndex <= `WUC_UPONLY_LAST)
      downNow = 1'b0;
    else
      downNow = hsDown;
    setNow  = (scanSrc == WUC_SET_WORDS) ? {scanWordHigh, scanWordLow}
                                         : scanConst;
    if (scanClear)
      curNew = '0;
    else if (edgeNow && downNow)
      curNew = curOld - `WUC_ONE;
    else if (edgeNow)
      curNew = curOld + `WUC_ONE;
    else
      curNew = curOld;
    next_p1Valid = scanGo;
    next_p1Index = scanIndex;
    next_p1Clear = scanClear;
    next_p1Edge  = edgeNow;
    next_p1Down  = downNow;
    next_p1Old   = curOld;
    next_p1New   = curNew;
    next_p1Set   = setNow;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p1Valid <= 1'b0;
      p1Index <= 8'h00;
      p1Clear <= 1'b0;
      p1Edge  <= 1'b0;
      p1Down  <= 1'b0;
      p1Old   <= '0;
      p1New   <= '0;
      p1Set   <= '0;
    end
    else
    begin
      p1Valid <= next_p1Valid;
      p1Index <= next_p1Index;
      p1Clear <= next_p1Clear;
      p1Edge  <= next_p1Edge;
      p1Down  <= next_p1Down;
      p1Old   <= next_p1Old;
      p1New   <= next_p1New;
      p1Set   <= next_p1Set;
    end
  end

  // Contact decision one cycle after the count step
  logic contactOn;
  logic contactOff;
  always_comb
  begin
    contactOn  = p1Edge && !p1Down && !p1Clear && (p1New == p1Set);
    contactOff = p1Clear ||
                 (p1Edge && p1Down && (p1Old == p1Set) &&
                  (p1New == p1Set - `WUC_ONE));
  end

  // Per-counter value, contact and input history
  for (genvar i = 0; i < `WUC_NUM_COUNTERS; i++)
  begin : g_cnt
    localparam logic [7:0] IDX    = 8'(i);
    localparam logic       RETAIN = (i >= RETAIN_BASE);
    wuc_word_type next_count;
    logic         next_contact;
    logic         next_prev;
    always_comb
    begin
      next_count   = counts[i];
      next_contact = contact[i];
      next_prev    = prevInput[i];
      if (powerFail && !RETAIN)
      begin
        next_count   = '0;
        next_contact = 1'b0;
        next_prev    = 1'b0;
      end
      else if (!powerFail)
      begin
        if (scanGo && scanIndex == IDX)
        begin
          next_count = curNew;
          next_prev  = scanInput;
        end
        if (p1Valid && p1Index == IDX)
        begin
          if (contactOff)
            next_contact = 1'b0;
          else if (contactOn)
            next_contact = 1'b1;
        end
      end
    end
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        counts[i]    <= '0;
        contact[i]   <= 1'b0;
        prevInput[i] <= 1'b0;
      end
      else
      begin
        counts[i]    <= next_count;
        contact[i]   <= next_contact;
        prevInput[i] <= next_prev;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic       dpValid;
  logic       dpWrite;
  logic [7:0] dpAddr;
  logic       next_dpValid;
  logic       next_dpWrite;
  logic [7:0] next_dpAddr;
  logic [63:0] next_dirBits;
  logic [7:0]  next_selIndex;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_comb
  begin
    next_dpValid  = hsel && htrans[1] && hready;
    next_dpWrite  = hwrite;
    next_dpAddr   = haddr;
    next_dirBits  = direction_select_bits;
    next_selIndex = selIndex;
    if (dpValid && dpWrite)
    begin
      case (dpAddr)
        `WUC_OFF_DIR_LO: next_dirBits[31:0]  = hwdata;
        `WUC_OFF_DIR_HI: next_dirBits[63:32] = hwdata;
        `WUC_OFF_SELECT: next_selIndex       = hwdata[7:0];
        default:         next_selIndex       = selIndex;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dpValid               <= 1'b0;
      dpWrite               <= 1'b0;
      dpAddr                <= 8'h00;
      direction_select_bits <= 64'h0;
      selIndex              <= 8'h00;
    end
    else
    begin
      dpValid               <= next_dpValid;
      dpWrite               <= next_dpWrite;
      dpAddr                <= next_dpAddr;
      direction_select_bits <= next_dirBits;
      selIndex              <= next_selIndex;
    end
  end

  // Read data built from registered state in the data phase
  always_comb
  begin
    hrdata = 32'h00000000;
    if (dpValid && !dpWrite)
    begin
      case (dpAddr)
        `WUC_OFF_DIR_LO:  hrdata = direction_select_bits[31:0];
        `WUC_OFF_DIR_HI:  hrdata = direction_select_bits[63:32];
        `WUC_OFF_SELECT:  hrdata = {24'h000000, selIndex};
        `WUC_OFF_VALUE:   hrdata = counts[selIndex];
        `WUC_OFF_CONTACT: hrdata = {31'h00000000, contact[selIndex]};
        default:          hrdata = 32'h00000000;
      endcase
    end
  end

  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_upHit;
    p1Valid && !powerFail && p1Edge && !p1Down && !p1Clear && (p1New == p1Set);
  endsequence
  sequence s_downLeave;
    p1Valid && !powerFail && p1Edge && p1Down && !p1Clear &&
    (p1Old == p1Set) && (p1New == p1Set - `WUC_ONE);
  endsequence
  property p_clearZero;
    scanGo && scanClear |=> counts[$past(scanIndex)] == '0 ##1 !contact[$past(scanIndex, 2)];
  endproperty
  a_clearZero: assert property (p_clearZero) else $error("clear left value or contact");
  property p_wrapUp;
    scanGo && !scanClear && edgeNow && !downNow && curOld == `WUC_MAX_POS
    |=> counts[$past(scanIndex)] == `WUC_MIN_NEG;
  endproperty
  a_wrapUp: assert property (p_wrapUp) else $error("no wrap at top");
  property p_wrapDown;
    scanGo && !scanClear && edgeNow && downNow && curOld == `WUC_MIN_NEG
    |=> counts[$past(scanIndex)] == `WUC_MAX_POS;
  endproperty
  a_wrapDown: assert property (p_wrapDown) else $error("no wrap at bottom");
  property p_contactOn;
    s_upHit |=> contact[$past(p1Index)];
  endproperty
  a_contactOn: assert property (p_contactOn) else $error("contact not set at match");
  property p_contactOff;
    s_downLeave |=> !contact[$past(p1Index)];
  endproperty
  a_contactOff: assert property (p_contactOff) else $error("contact not cleared");
  property p_contactLate;
    !$stable(contact) |-> $past(p1Valid) || $past(powerFail);
  endproperty
  a_contactLate: assert property (p_contactLate) else $error("contact moved early");
  property p_upOnly;
    scanGo && !scanClear && edgeNow && scanIndex > `WUC_UPDOWN_LAST &&
    scanIndex <= `WUC_UPONLY_LAST
    |=> counts[$past(scanIndex)] == $past(curOld) + `WUC_ONE;
  endproperty
  a_upOnly: assert property (p_upOnly) else $error("up-only counter did not add");
  property p_pastSet;
    scanGo && !scanClear && edgeNow && !downNow && curOld == setNow
    |=> counts[$past(scanIndex)] == $past(setNow) + `WUC_ONE;
  endproperty
  a_pastSet: assert property (p_pastSet) else $error("counter halted at setting");
  property p_noEdgeHold;
    scanGo && !scanClear && !edgeNow |=> counts[$past(scanIndex)] == $past(curOld);
  endproperty
  a_noEdgeHold: assert property (p_noEdgeHold) else $error("count without edge");
  property p_powerClear;
    powerFail |=> counts[RETAIN_BASE - 1] == '0 && !contact[RETAIN_BASE - 1];
  endproperty
  a_powerClear: assert property (p_powerClear) else $error("volatile counter kept");
  property p_powerKeep;
    powerFail |=> $stable(counts[RETAIN_BASE]) && $stable(contact[RETAIN_BASE]);
  endproperty
  a_powerKeep: assert property (p_powerKeep) else $error("retentive counter lost");
endmodule

// File: test/wuc_scan_model.sv
// Controller scan model: presents count edges, clears and setting values
`timescale 1ns/1ps
module wuc_scan_model (
  // Clock
  input  wire logic               clk,
  // Scan step outputs
  output logic                    scanValid,
  output logic [7:0]              scanIndex,
  output logic                    scanInput,
  output logic                    scanClear,
  output wuc_pkg::wuc_setsrc_type scanSrc,
  output wuc_pkg::wuc_word_type   scanConst,
  output logic [15:0]             scanWordLow,
  output logic [15:0]             scanWordHigh
);
  import wuc_pkg::*;

  initial
  begin
    scanValid = 1'b0;
    scanIndex = 8'h00;
    scanInput = 1'b0;
    scanClear = 1'b0;
    scanSrc = WUC_SET_CONST;
    scanConst = 32'h00000000;
    {scanWordHigh, scanWordLow} = 32'h00000000;
  end

  // One scan step; the unused setting source carries junk so a wrong pick shows
  task automatic step(input logic [7:0] i, input logic lvl, input logic clr,
                      input logic [31:0] sv);
    @(posedge clk);
    scanValid <= 1'b1;
    scanIndex <= i;
    scanInput <= lvl;
    scanClear <= clr;
    scanSrc <= sv[0] ? WUC_SET_WORDS : WUC_SET_CONST;
    scanConst <= sv[0] ? ~sv : sv;
    {scanWordHigh, scanWordLow} <= sv[0] ? sv : ~sv;
    @(posedge clk);
    scanValid <= 1'b0;
    scanIndex <= ~i;
    scanInput <= ~lvl;
    scanClear <= ~clr;
  endtask

  // Input low in one scan, high in the next: always a distinct rising edge
  task automatic pulse(input logic [7:0] i, input logic clr, input logic [31:0] sv);
    step(i, 1'b0, 1'b0, sv);
    step(i, 1'b1, clr, sv);
  endtask
endmodule

// File: test/wuc_counter_bank_tb.sv
// Self-checking bench of the counter bank: registers, edges, clear and power loss
`timescale 1ns/1ps
`include "wuc_defs.svh"
module wuc_counter_bank_tb;
  import wuc_pkg::*;
  localparam int RB = 100;
  logic                  clk;
  logic                  nrst;
  logic                  hsel;
  logic                  hwrite;
  logic                  hreadyout;
  logic                  hresp;
  logic                  hsDown;
  logic                  powerFail;
  logic [7:0]            haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic                  scanValid;
  logic [7:0]            scanIndex;
  logic                  scanInput;
  logic                  scanClear;
  wuc_setsrc_type        scanSrc;
  wuc_word_type          scanConst;
  logic [15:0]           scanWordLow;
  logic [15:0]           scanWordHigh;
  logic [255:0]          contact;
  logic [63:0]           dirs;
  logic [31:0]           ev [256];
  logic                  ec [256];
  int                    n_errors = 0;
  int                    tests_run = 0;

  wuc_scan_model m (.clk(clk), .scanValid(scanValid), .scanIndex(scanIndex),
    .scanInput(scanInput), .scanClear(scanClear), .scanSrc(scanSrc),
    .scanConst(scanConst), .scanWordLow(scanWordLow), .scanWordHigh(scanWordHigh));

  wuc_counter_bank #(.RETAIN_BASE(RB)) dut (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .scanValid(scanValid), .scanIndex(scanIndex), .scanInput(scanInput),
    .scanClear(scanClear), .hsDown(hsDown), .scanSrc(scanSrc), .scanConst(scanConst),
    .scanWordLow(scanWordLow), .scanWordHigh(scanWordHigh), .powerFail(powerFail),
    .contact(contact));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // hready and read data are taken at the rising edge that ends each phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'b10, a, wr, 3'b010};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  function automatic logic dnOf(input int i);
    return (i < 64) ? dirs[i] : ((i >= 200) ? hsDown : 1'b0);
  endfunction

  function automatic logic ctc(input logic c, input logic [31:0] nv, input logic dn,
                               input logic [31:0] sv);
    if (!dn && nv == sv)
      return 1'b1;
    if (dn && nv == sv - 32'h1)
      return 1'b0;
    return c;
  endfunction

  task automatic hit(input int i, input logic [31:0] sv, input logic clr);
    logic dn;
    dn = dnOf(i);
    m.pulse(8'(i), clr, sv);
    ev[i] = clr ? 32'h0 : (dn ? ev[i] - 32'h1 : ev[i] + 32'h1);
    ec[i] = clr ? 1'b0 : ctc(ec[i], ev[i], dn, sv);
    repeat (2) @(posedge clk);
  endtask

  task automatic vfy(input int i);
    logic [31:0] r;
    bus(1'b1, `WUC_OFF_SELECT, 32'(i), r);
    bus(1'b0, `WUC_OFF_VALUE, 32'h0, r);
    chk("value", ev[i], r);
    bus(1'b0, `WUC_OFF_CONTACT, 32'h0, r);
    chk("contact reg", {31'h0, ec[i]}, r);
    chk("contact pin", {31'h0, ec[i]}, {31'h0, contact[i]});
  endtask

  task automatic setDir;
    logic [31:0] r;
    bus(1'b1, `WUC_OFF_DIR_LO, dirs[31:0], r);
    bus(1'b1, `WUC_OFF_DIR_HI, dirs[63:32], r);
    bus(1'b0, `WUC_OFF_DIR_HI, 32'h0, r);
    chk("dir hi", dirs[63:32], r);
  endtask

  initial
  begin
    #(40 * 30000);
    n_errors++;
    close_out();
  end

  initial
  begin
    logic [31:0] r;
    int k;
    int i;
    {nrst, hsel, haddr, htrans, hwrite, hsize, hwdata, hsDown, powerFail} = '0;
    dirs = '0;
    foreach (ev[j]) ev[j] = 32'h0;
    foreach (ec[j]) ec[j] = 1'b0;
    void'($urandom(32'h7384));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 6; k++)
    begin
      bus(1'b0, 8'(4 * k), 32'h0, r);
      chk("reset read", 32'h0, r);
    end
    $display("reset values done");
    for (k = 0; k < 4; k++)
    begin
      hit(5, 32'h3, 1'b0);
      vfy(5);
    end
    dirs[5] = 1'b1;
    setDir();
    hit(5, 32'h3, 1'b0);
    hit(5, 32'h3, 1'b0);
    vfy(5);
    dirs[5] = 1'b0;
    setDir();
    hit(5, 32'h3, 1'b0);
    hit(5, 32'h3, 1'b1);
    vfy(5);
    $display("match and clear done");
    for (k = 0; k < 16; k++)
    begin
      dirs = {$urandom, $urandom};
      setDir();
      i = $urandom % 64;
      hit(i, ev[i] + 32'($urandom % 3) - 32'h1, 1'b0);
      vfy(i);
    end
    $display("random steps done");
    hit(100, 32'h2, 1'b0);
    hit(100, 32'h2, 1'b0);
    hit(99, 32'h7, 1'b0);
    hit(5, 32'hfffffffb, 1'b0);
    @(posedge clk);
    powerFail <= 1'b1;
    @(posedge clk);
    powerFail <= 1'b0;
    for (k = 0; k < RB; k++)
    begin
      ev[k] = 32'h0;
      ec[k] = 1'b0;
    end
    vfy(5);
    vfy(99);
    vfy(100);
    hit(100, 32'h2, 1'b0);
    vfy(100);
    $display("power loss done");
    hit(210, 32'h1, 1'b0);
    @(posedge clk);
    hsDown <= 1'b1;
    @(posedge clk);
    hit(210, 32'h1, 1'b0);
    vfy(210);
    hit(220, 32'h0, 1'b0);
    hit(220, 32'h0, 1'b0);
    @(posedge clk);
    hsDown <= 1'b0;
    @(posedge clk);
    hit(220, 32'hffffffff, 1'b0);
    vfy(220);
    $display("high speed done");
    close_out();
  end
endmodule
